// ---- verilog/dac_pkg.sv ----
// shared constants and types for the dual converter control block
// assumes a single 200 MHz system clock and a 32-bit AXI4-Lite register bus
package dac_pkg;

   localparam int DATA_W      = 10;
   localparam int SYS_CLK_MHZ = 200;
   localparam int SAMPLE_MHZ  = 40;
   localparam int CLK_DIV     = SYS_CLK_MHZ / SAMPLE_MHZ;
   localparam int CLK_HALF    = CLK_DIV / 2;
   localparam int PIPE_DEPTH  = 3;
   localparam int TRIM_CYCLES = 34;
   localparam int TRIM_AVG    = 32;
   localparam int TRIM_SHIFT  = 5;
   localparam int N_CH        = 2;

   localparam logic [9:0] MID_CODE = 10'h200;
   localparam logic [9:0] MAX_CODE = 10'h3FF;
   localparam logic [9:0] MIN_CODE = 10'h000;

   localparam int         ADDR_W     = 8;
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_OFFSET = 8'h08;
   localparam logic [7:0] REG_LAST   = 8'h0C;

   localparam int CTRL_TRIM_BIT   = 0;
   localparam int CTRL_CLR_BIT    = 1;
   localparam int STAT_BUSY_BIT   = 2;
   localparam int STAT_DONE_BIT   = 3;
   localparam int STAT_LAYOUT_BIT = 4;
   localparam int STAT_FORMAT_BIT = 5;
   localparam int STAT_GAIN_BIT   = 6;
   localparam int HI_LSB          = 16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PWR_RUN, PWR_QUICK, PWR_DEEP} dac_pwr_t;

endpackage

// ---- verilog/dac_trim_acc.sv ----
// offset trim accumulator for one converter channel
// assumes start is a one-cycle pulse and sample_en marks each conversion
module dac_trim_acc
   import dac_pkg::*;
#(
   parameter int DW = DATA_W
)(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 start,
   input  wire logic                 sample_en,
   input  wire logic [DW-1:0]        raw,
   output logic signed [DW-1:0]      offset,
   output logic                      busy,
   output logic                      done
);

   localparam int SUM_W = DW + TRIM_SHIFT + 1;

   logic        [5:0]       cnt_reg;
   logic signed [SUM_W-1:0] sum_reg;
   logic signed [DW-1:0]    offset_reg;
   logic                    busy_reg;
   logic                    done_reg;
   wire  logic signed [DW:0] dev;
   wire  logic              last;
   wire  logic              acc_en;

   // deviation of the raw code from the zero-input code
   assign dev    = $signed({1'b0, raw}) - $signed({1'b0, MID_CODE});
   assign last   = (cnt_reg == 6'(TRIM_CYCLES - 1));
   assign acc_en = (cnt_reg < 6'(TRIM_AVG));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg    <= 6'h00;
         sum_reg    <= '0;
         offset_reg <= '0;
         busy_reg   <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            busy_reg <= 1'b1;
            cnt_reg  <= 6'h00;
            sum_reg  <= '0;
         end else if (busy_reg && sample_en) begin
            cnt_reg <= cnt_reg + 6'h01;
            if (acc_en) begin
               sum_reg <= sum_reg + SUM_W'(dev);
            end
            if (last) begin
               busy_reg   <= 1'b0;
               done_reg   <= 1'b1;
               offset_reg <= sum_reg[TRIM_SHIFT+DW-1:TRIM_SHIFT];
            end
         end
      end
   end

   assign offset = offset_reg;
   assign busy   = busy_reg;
   assign done   = done_reg;

endmodule // dac_trim_acc

// ---- verilog/dac_top.sv ----
// control and output side of a dual 10-bit sampling converter
// assumes raw codes come from the converter core on aclk, control pins
// are asynchronous, and software uses an AXI4-Lite master
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
module dac_top
   import dac_pkg::*;
#(
   parameter int DW  = DATA_W,
   parameter int DIV = CLK_DIV
)(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [DW-1:0]     raw_i,
   input  wire logic [DW-1:0]     raw_q,
   input  wire logic              bus_layout_select,
   input  wire logic              offset_trim_trigger,
   input  wire logic              code_format_select,
   input  wire logic              quick_sleep_pin,
   input  wire logic              deep_sleep_pin,
   input  wire logic              gain_select_pin,
   output logic [DW-1:0]          data_i,
   output logic [DW-1:0]          data_q,
   output logic                   iq_sel,
   output logic                   sample_clk,
   output logic                   afe_gain,
   output logic                   afe_standby,
   output logic                   afe_powerdown,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   localparam int NPIN = 6;
   localparam int P_LAYOUT = 0;
   localparam int P_TRIM   = 1;
   localparam int P_FORMAT = 2;
   localparam int P_QUICK  = 3;
   localparam int P_DEEP   = 4;
   localparam int P_GAIN   = 5;
   localparam int HALF     = DIV / 2;

   // pin synchronisers
   logic [NPIN-1:0] pin_meta_reg;
   logic [NPIN-1:0] pin_sync_reg;
   logic            trim_prev_reg;
   wire  logic [NPIN-1:0] pin_raw;

   // sample clock divider
   logic [7:0] div_cnt_reg;
   logic       sample_clk_reg;
   wire  logic rise_pulse;
   wire  logic fall_pulse;

   // power state
   dac_pwr_t pwr_reg;
   dac_pwr_t pwr_next;
   wire  logic run;
   wire  logic cap_en;
   wire  logic out_rise;
   wire  logic out_fall;

   // trim control
   wire  logic trim_pin_rise;
   wire  logic trim_start;
   logic       sw_trim_reg;
   logic       done_reg;
   wire  logic [N_CH-1:0] trim_busy;
   wire  logic [N_CH-1:0] trim_done;
   wire  logic signed [DW-1:0] offset_ch [N_CH];
   wire  logic [DW-1:0] raw_ch [N_CH];
   wire  logic [DW-1:0] tail_ch [N_CH];

   // output registers
   logic [DW-1:0] data_i_reg;
   logic [DW-1:0] data_q_reg;
   logic          iq_sel_reg;
   logic          afe_gain_reg;
   logic          afe_standby_reg;
   logic          afe_powerdown_reg;
   wire  logic    layout_par;
   wire  logic    fmt_twos;
   wire  logic [DW-1:0] fmt_i;
   wire  logic [DW-1:0] fmt_q;

   // bus slave
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   wire  logic  wr_go;
   wire  logic  wr_fire;
   wire  logic  rd_go;
   wire  logic  rd_fire;
   wire  logic  wr_ctrl;
   wire  logic  wr_hit;
   wire  logic  rd_hit;
   wire  logic  clr_done;
   wire  logic [31:0] stat_word;
   wire  logic [31:0] off_word;
   wire  logic [31:0] last_word;
   wire  logic [31:0] rd_word;

   assign pin_raw = {gain_select_pin, deep_sleep_pin, quick_sleep_pin,
                     code_format_select, offset_trim_trigger,
                     bus_layout_select};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_reg  <= '0;
         pin_sync_reg  <= '0;
         trim_prev_reg <= 1'b0;
      end else begin
         pin_meta_reg  <= pin_raw;
         pin_sync_reg  <= pin_meta_reg;
         trim_prev_reg <= pin_sync_reg[P_TRIM];
      end
   end

   // sample clock: high for the first HALF (DIV / 2) aclk cycles of each divider period
   assign rise_pulse = (div_cnt_reg == 8'h00);
   assign fall_pulse = (div_cnt_reg == 8'(HALF));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_reg    <= 8'h00;
         sample_clk_reg <= 1'b0;
      end else begin
         if (div_cnt_reg == 8'(DIV - 1)) begin
            div_cnt_reg <= 8'h00;
         end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
         end
         if (rise_pulse) begin
            sample_clk_reg <= 1'b1;
         end else if (fall_pulse) begin
            sample_clk_reg <= 1'b0;
         end
      end
   end

   // power state from the sleep pins
   always_comb begin
      case ({pin_sync_reg[P_DEEP], pin_sync_reg[P_QUICK]})
         2'h0:    pwr_next = PWR_RUN;
         2'h1:    pwr_next = PWR_QUICK;
         2'h2:    pwr_next = PWR_DEEP;
         2'h3:    pwr_next = PWR_DEEP;
         default: pwr_next = PWR_DEEP;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_reg           <= PWR_RUN;
         afe_standby_reg   <= 1'b0;
         afe_powerdown_reg <= 1'b0;
         afe_gain_reg      <= 1'b0;
      end else begin
         pwr_reg           <= pwr_next;
         afe_standby_reg   <= (pwr_next == PWR_QUICK);
         afe_powerdown_reg <= (pwr_next == PWR_DEEP);
         afe_gain_reg      <= pin_sync_reg[P_GAIN];
      end
   end

   assign run      = (pwr_reg == PWR_RUN);
   assign cap_en   = fall_pulse && run;
   assign out_rise = rise_pulse && run;
   assign out_fall = fall_pulse && run;

   // trim start from pin edge or software
   assign trim_pin_rise = pin_sync_reg[P_TRIM] && !trim_prev_reg;
   assign trim_start    = trim_pin_rise || sw_trim_reg;
   assign raw_ch[0]     = raw_i;
   assign raw_ch[1]     = raw_q;

   genvar ch;
   generate
      for (ch = 0; ch < N_CH; ch = ch + 1) begin : gen_ch
         logic        [DW-1:0] pipe_reg [PIPE_DEPTH];
         wire  logic signed [DW+1:0] diff;
         wire  logic  [DW-1:0] corr;

         dac_trim_acc #(
            .DW (DW)
         ) u_trim (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .start     (trim_start),
            .sample_en (cap_en),
            .raw       (raw_ch[ch]),
            .offset    (offset_ch[ch]),
            .busy      (trim_busy[ch]),
            .done      (trim_done[ch])
         );

         // corrected code clamps, so usable range shrinks by the offset
         assign diff = $signed({2'h0, raw_ch[ch]})
                     - $signed({{2{offset_ch[ch][DW-1]}}, offset_ch[ch]});
         assign corr = (diff < 0) ? MIN_CODE :
                       (diff > $signed({2'h0, MAX_CODE})) ? MAX_CODE :
                       diff[DW-1:0];

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               for (int k = 0; k < PIPE_DEPTH; k++) begin
                  pipe_reg[k] <= MID_CODE;
               end
            end else if (cap_en) begin
               pipe_reg[0] <= corr;
               for (int k = 1; k < PIPE_DEPTH; k++) begin
                  pipe_reg[k] <= pipe_reg[k-1];
               end
            end
         end

         assign tail_ch[ch] = pipe_reg[PIPE_DEPTH-1];
      end
   endgenerate

   // output coding
   assign fmt_twos   = pin_sync_reg[P_FORMAT];
   assign layout_par = pin_sync_reg[P_LAYOUT];
   assign fmt_i = {tail_ch[0][DW-1] ^ fmt_twos, tail_ch[0][DW-2:0]};
   assign fmt_q = {tail_ch[1][DW-1] ^ fmt_twos, tail_ch[1][DW-2:0]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_i_reg <= MID_CODE;
         data_q_reg <= MIN_CODE;
         iq_sel_reg <= 1'b0;
      end else begin
         if (out_rise) begin
            data_i_reg <= fmt_i;
            iq_sel_reg <= 1'b1;
            if (layout_par) begin
               data_q_reg <= fmt_q;
            end else begin
               data_q_reg <= MIN_CODE;
            end
         end else if (out_fall) begin
            iq_sel_reg <= 1'b0;
            if (!layout_par) begin
               data_i_reg <= fmt_q;
            end
         end
      end
   end

   // register bus: write and read paths
   assign wr_go   = s_axi_awvalid && s_axi_wvalid && !awready_reg
                    && !bvalid_reg;
   assign wr_fire = awready_reg;
   assign rd_go   = s_axi_arvalid && !arready_reg && !rvalid_reg;
   assign rd_fire = arready_reg;
   assign wr_ctrl = wr_fire && (s_axi_awaddr == REG_CTRL)
                    && s_axi_wstrb[0];
   assign wr_hit  = (s_axi_awaddr == REG_CTRL)
                    || (s_axi_awaddr == REG_STATUS)
                    || (s_axi_awaddr == REG_OFFSET)
                    || (s_axi_awaddr == REG_LAST);
   assign rd_hit  = (s_axi_araddr == REG_CTRL)
                    || (s_axi_araddr == REG_STATUS)
                    || (s_axi_araddr == REG_OFFSET)
                    || (s_axi_araddr == REG_LAST);
   assign clr_done = wr_ctrl && s_axi_wdata[CTRL_CLR_BIT];

   assign stat_word = {25'h0, afe_gain_reg, fmt_twos, layout_par, done_reg,
                       |trim_busy, 2'(pwr_reg)};
   assign off_word  = {6'h0, offset_ch[1], 6'h0, offset_ch[0]};
   assign last_word = {6'h0, data_q_reg, 6'h0, data_i_reg};
   assign rd_word   = (s_axi_araddr == REG_STATUS) ? stat_word :
                      (s_axi_araddr == REG_OFFSET) ? off_word :
                      (s_axi_araddr == REG_LAST)   ? last_word :
                      32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         sw_trim_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else begin
         awready_reg <= wr_go;
         wready_reg  <= wr_go;
         sw_trim_reg <= wr_ctrl && s_axi_wdata[CTRL_TRIM_BIT];
         done_reg    <= (|trim_done) || (done_reg && !clr_done);
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         arready_reg <= rd_go;
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign data_i        = data_i_reg;
   assign data_q        = data_q_reg;
   assign iq_sel        = iq_sel_reg;
   assign sample_clk    = sample_clk_reg;
   assign afe_gain      = afe_gain_reg;
   assign afe_standby   = afe_standby_reg;
   assign afe_powerdown = afe_powerdown_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

endmodule // dac_top

// ---- testbench/dac_top_props.sv ----
// assertions on the output pins of the dual converter control block
// assumes a bind to dac_top and a free-running sample clock divider
module dac_top_props
   import dac_pkg::*;
#(
   parameter int DW  = DATA_W,
   parameter int DIV = CLK_DIV
)(
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          bus_layout_select,
   input wire logic          quick_sleep_pin,
   input wire logic          deep_sleep_pin,
   input wire logic          gain_select_pin,
   input wire logic [DW-1:0] data_i,
   input wire logic [DW-1:0] data_q,
   input wire logic          iq_sel,
   input wire logic          sample_clk,
   input wire logic          afe_gain,
   input wire logic          afe_standby,
   input wire logic          afe_powerdown
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] settle;
   logic [7:0] slp_sh;
   logic [7:0] dp_sh;
   logic [7:0] mux_sh;
   logic [7:0] gn_sh;
   logic [7:0] per_cnt;
   logic       sc_d;
   wire        ok   = (settle == 3'h7);
   wire        rise = sample_clk & ~sc_d;
   wire        slp  = quick_sleep_pin | deep_sleep_pin;

   // pin history and sample period counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle  <= 3'h0;
         slp_sh  <= 8'h00;
         dp_sh   <= 8'h00;
         mux_sh  <= 8'h00;
         gn_sh   <= 8'h00;
         per_cnt <= 8'h00;
         sc_d    <= 1'b0;
      end else begin
         settle  <= ok ? settle : settle + 3'h1;
         slp_sh  <= {slp_sh[6:0], slp};
         dp_sh   <= {dp_sh[6:0], deep_sleep_pin};
         mux_sh  <= {mux_sh[6:0], ~bus_layout_select};
         gn_sh   <= {gn_sh[6:0], gain_select_pin};
         per_cnt <= rise ? 8'h01 :
                    (per_cnt == 8'h00) ? 8'h00 : per_cnt + 8'h01;
         sc_d    <= sample_clk;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_high;
      sample_clk;
   endsequence
   sequence s_low;
      !sample_clk [*3] ##1 sample_clk;
   endsequence

   property p_clk_shape;
      $rose(sample_clk) |=> s_high ##1 s_low;
   endproperty
   property p_period;
      rise && per_cnt != 8'h00 |-> per_cnt == DIV;
   endproperty
   property p_iq_sel;
      ok && slp_sh == 8'h00 |-> iq_sel == sample_clk;
   endproperty
   property p_q_low;
      ok && (&mux_sh) |-> data_q == '0;
   endproperty
   property p_i_edges;
      ok && $changed(data_i) |-> $changed(sample_clk);
   endproperty
   property p_q_edges;
      ok && $changed(data_q) |-> $rose(sample_clk);
   endproperty
   property p_hold;
      (&slp_sh) && slp |-> $stable(data_i) && $stable(data_q);
   endproperty
   property p_deep;
      &dp_sh |-> afe_powerdown && !afe_standby;
   endproperty
   property p_quick;
      (&slp_sh) && dp_sh == 8'h00 |-> afe_standby && !afe_powerdown;
   endproperty
   property p_run;
      ok && slp_sh == 8'h00 |-> !afe_standby && !afe_powerdown;
   endproperty
   property p_gain;
      ok && (gn_sh == 8'hFF || gn_sh == 8'h00) |-> afe_gain == gn_sh[0];
   endproperty

   a_clk_shape: assert property (p_clk_shape)
      else $error("sample clock duty wrong");
   a_period: assert property (p_period)
      else $error("sample period wrong");
   a_iq_sel: assert property (p_iq_sel)
      else $error("channel marker out of step");
   a_q_low: assert property (p_q_low)
      else $error("second bus not low when multiplexed");
   a_i_edges: assert property (p_i_edges)
      else $error("first bus changed off a clock edge");
   a_q_edges: assert property (p_q_edges)
      else $error("second bus changed off a rise");
   a_hold: assert property (p_hold)
      else $error("outputs moved in sleep");
   a_deep: assert property (p_deep)
      else $error("deep sleep not taken");
   a_quick: assert property (p_quick)
      else $error("quick sleep not taken");
   a_run: assert property (p_run)
      else $error("sleep flag without sleep pin");
   a_gain: assert property (p_gain)
      else $error("gain not forwarded");
endmodule // dac_top_props

bind dac_top dac_top_props #(.DW(DW), .DIV(DIV)) i_dac_top_props (
   .aclk(aclk), .aresetn(aresetn), .bus_layout_select(bus_layout_select),
   .quick_sleep_pin(quick_sleep_pin), .deep_sleep_pin(deep_sleep_pin),
   .gain_select_pin(gain_select_pin), .data_i(data_i), .data_q(data_q),
   .iq_sel(iq_sel), .sample_clk(sample_clk), .afe_gain(afe_gain),
   .afe_standby(afe_standby), .afe_powerdown(afe_powerdown));

// ---- testbench/dac_host_cap.sv ----
// host capture model latching the converter output buses
// assumes bus data and sample_clk change on aclk rising edges
module dac_host_cap
   import dac_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              sample_clk,
   input  wire logic              bus_layout_select,
   input  wire logic [DATA_W-1:0] data_i,
   input  wire logic [DATA_W-1:0] data_q,
   output logic      [DATA_W-1:0] cap_i,
   output logic      [DATA_W-1:0] cap_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sc_d = 1'b0;

   // latch first bus after rise, second word after fall when multiplexed
   always_ff @(posedge aclk) begin
      sc_d <= sample_clk;
      if (sample_clk && !sc_d) begin
         cap_i <= data_i;
         if (bus_layout_select)
            cap_q <= data_q;
      end
      if (!sample_clk && sc_d && !bus_layout_select)
         cap_q <= data_i;
   end
endmodule // dac_host_cap

// ---- testbench/tb_dac_top.sv ----
// self-checking bench for the dual converter control block
// assumes dac_top with DIV 5, host capture model and AXI4-Lite tasks
module tb_dac_top;
   import dac_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DV = 5;
   logic        aclk, aresetn, lay, trg, fmt, qs, ds, gn;
   logic [9:0]  raw_i, raw_q, data_i, data_q, cap_i, cap_q;
   logic        sample_clk, afe_gain, afe_stb, afe_pd;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, rs;
   int          bad_count = 0;
   int          checks_done = 0;
   int          n;

   dac_top #(.DIV(DV)) i_dac_top (
      .aclk(aclk), .aresetn(aresetn), .raw_i(raw_i), .raw_q(raw_q),
      .bus_layout_select(lay), .offset_trim_trigger(trg),
      .code_format_select(fmt), .quick_sleep_pin(qs),
      .deep_sleep_pin(ds), .gain_select_pin(gn), .data_i(data_i),
      .data_q(data_q), .iq_sel(), .sample_clk(sample_clk),
      .afe_gain(afe_gain), .afe_standby(afe_stb), .afe_powerdown(afe_pd),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   dac_host_cap i_dac_host_cap (.aclk(aclk), .sample_clk(sample_clk),
      .bus_layout_select(lay), .data_i(data_i), .data_q(data_q),
      .cap_i(cap_i), .cap_q(cap_q));

   task conclude;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [9:0] g, input logic [9:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   task wt(input int p);
      repeat (p * DV) @(posedge aclk);
   endtask

   task expire(input int lim);
      if (n >= lim) begin
         bad_count++;
         conclude;
      end
   endtask

   task axw(input logic [7:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
      expire(40);
   endtask

   task axr(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      expire(40);
   endtask

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      {aresetn, trg, fmt, qs, ds, gn, awvalid, wvalid, bready} = '0;
      {arvalid, rready, awaddr, araddr, wdata} = '0;
      lay = 1'b1;
      raw_i = 10'h123;
      raw_q = 10'h2AB;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      // parallel buses in both codings, offsets still zero
      for (int f = 0; f < 2; f++) begin
         fmt <= f[0];
         wt(8);
         chk(cap_i, 10'h123 ^ {f[0], 9'h000});
         chk(cap_q, 10'h2AB ^ {f[0], 9'h000});
      end
      gn <= 1'b1;
      fmt <= 1'b0;
      lay <= 1'b0;
      wt(8);
      chk({9'h000, afe_gain}, 10'h001);
      chk(cap_i, 10'h123);
      chk(cap_q, 10'h2AB);
      chk(data_q, 10'h000);
      // latency: new word captured at next fall shows on third rise
      lay <= 1'b1;
      wt(8);
      for (n = 0; n < 20 && !(sample_clk && !i_dac_host_cap.sc_d); n++)
         @(posedge aclk);
      expire(20);
      raw_i <= 10'h0F0;
      rs = 2'h0;
      for (n = 0; n < 40 && data_i !== 10'h0F0; n++) begin
         @(posedge aclk);
         if (sample_clk && !i_dac_host_cap.sc_d) rs = rs + 2'h1;
      end
      expire(40);
      chk({8'h00, rs}, 10'h003);
      // trim with inputs held at a known offset
      raw_i <= 10'h205;
      raw_q <= 10'h1FD;
      wt(2);
      trg <= 1'b1;
      wt(32);
      axr(REG_STATUS);
      chk({8'h00, rd[3:2]}, 10'h001);
      wt(4);
      axr(REG_STATUS);
      chk({8'h00, rd[3:2]}, 10'h002);
      axr(REG_OFFSET);
      chk(rd[9:0], 10'h005);
      chk(rd[25:16], 10'h3FD);
      raw_i <= 10'h300;
      raw_q <= 10'h100;
      wt(8);
      chk(cap_i, 10'h2FB);
      chk(cap_q, 10'h103);
      // second trim started from the control register, zero input
      trg <= 1'b0;
      raw_i <= 10'h200;
      raw_q <= 10'h200;
      axw(REG_CTRL, 32'h0000_0001);
      wt(36);
      axr(REG_OFFSET);
      chk(rd[9:0], 10'h000);
      chk(rd[25:16], 10'h000);
      axr(8'h40);
      chk({8'h00, rs}, {8'h00, RESP_SLVERR});
      chk(rd[9:0], 10'h000);
      axw(8'h40, 32'h0000_0001);
      chk({8'h00, rs}, {8'h00, RESP_SLVERR});
      axw(REG_CTRL, 32'h0000_0002);
      axr(REG_STATUS);
      chk({8'h00, rd[3:2]}, 10'h000);
      // sleep states freeze the last result
      raw_i <= 10'h111;
      wt(8);
      qs <= 1'b1;
      wt(2);
      raw_i <= 10'h222;
      wt(8);
      chk(data_i, 10'h111);
      chk({afe_pd, afe_stb}, 10'h001);
      ds <= 1'b1;
      wt(2);
      chk({afe_pd, afe_stb}, 10'h002);
      chk(data_i, 10'h111);
      qs <= 1'b0;
      ds <= 1'b0;
      wt(8);
      chk(data_i, 10'h222);
      conclude;
   end
endmodule // tb_dac_top
